// >>> rtl/rx_pma_status_pkg.sv
// rx_pma_status_pkg: constants, register map and types for rx_pma_status
// assumes a single 10 MHz core clock and a 32-bit APB register port
package rx_pma_status_pkg;

  // apb geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;

  // register byte offsets
  localparam logic [ADDR_W-1:0] CTRL_OFF = 8'h00;
  localparam logic [ADDR_W-1:0] STATUS_OFF = 8'h04;
  localparam logic [ADDR_W-1:0] ERRCNT_OFF = 8'h08;
  localparam logic [ADDR_W-1:0] IRQ_STAT_OFF = 8'h0C;
  localparam logic [ADDR_W-1:0] IRQ_CLR_OFF = 8'h10;
  localparam logic [ADDR_W-1:0] IRQ_EN_OFF = 8'h14;

  // control register layout, bit 4 downward
  typedef struct packed {
    logic detectStart;
    logic prbsClear;
    logic levelEn;
    logic forceRef;
    logic forceData;
  } ctrl_s;
  localparam int CTRL_W = 5;
  localparam logic [CTRL_W-1:0] CTRL_RST = 5'h04;

  // event layout, shared by irq status, clear and enable
  typedef struct packed {
    logic lockLost;
    logic slip;
    logic prbsErr;
    logic prbsDone;
    logic rxFound;
  } evt_s;
  localparam int EVT_W = 5;
  localparam logic [EVT_W-1:0] IRQ_EN_RST = 5'h00;

  // status register width
  localparam int STATUS_W = 7;

  // error counter
  localparam int ERRCNT_W = 16;

  // pattern verifier
  localparam int PRBS_ORDER = 7;
  localparam int PRBS_PERIOD = 127;
  localparam int MATCH_W = 8;

  // error hold length in core clock cycles
  localparam logic [1:0] ERR_HOLD = 2'h3;

  // far-end receiver detect timing
  localparam int CLK_PERIOD_NS = 100;
  localparam int DETECT_TIME_NS = 10000;
  localparam int DETECT_CYC =
    (DETECT_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DET_CNT_W = 8;
  localparam logic [DET_CNT_W-1:0] DETECT_LOAD = DET_CNT_W'(DETECT_CYC - 1);

  // receiver detect sequencer
  typedef enum logic [2:0] {
    DET_IDLE = 3'b001,
    DET_CHARGE = 3'b010,
    DET_SAMPLE = 3'b100
  } detect_state_e;

endpackage

// >>> rtl/rx_pma_status.sv
// rx_pma_status: receive status, lock control, pattern verifier, level
// detect and far-end receiver detect, with an APB register port
// assumes all pin inputs are synchronous to core_clk and that the
// parallel word strobe is already retimed to core_clk, high one cycle per word
//
// Contract
// - receiver-found output rises once a far-end receiver is sensed
// - clock-slip output flags each dropped bit or paused serial clock
// - data-lock flag is high while recovery is locked to data
// - reference-lock flag is high while recovery is locked to reference
// - done only after alignment, capture and a full polynomial pass
// - no mismatch is reported before the done flag is high
// - each mismatch holds the error output high three cycles
// - at most one mismatch is reported per received word
// - clear resets pattern state and drops done so alignment restarts
// - level detect output follows the input level threshold comparator
//
// The register addresses and the APB interface to the registers are this design's own decisions.
`timescale 1ns/10ps

module rx_pma_status #(
  parameter int WORD_W = 10
) (
  // clock and reset
  input wire logic core_clk,
  input wire logic rst_b,
  // apb slave
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [rx_pma_status_pkg::ADDR_W-1:0] paddr,
  input wire logic [rx_pma_status_pkg::DATA_W-1:0] pwdata,
  output logic [rx_pma_status_pkg::DATA_W-1:0] prdata,
  output logic pready,
  output logic pslverr,
  // recovery loop raw lock indications and overrides
  input wire logic cdrDataLock,
  input wire logic cdrRefLock,
  input wire logic forceDataLock,
  input wire logic forceRefLock,
  output logic dataLockFlag,
  output logic referenceLockFlag,
  // deserializer word alignment slip
  input wire logic slipDropBit,
  input wire logic slipPauseClk,
  output logic clkSlip,
  // pattern verifier
  input wire logic wordValid,
  input wire logic [WORD_W-1:0] rxWord,
  input wire logic prbsClear,
  output logic prbsDone,
  output logic prbsErr,
  // input level detect
  input wire logic levelAbove,
  output logic inputLevelDetect,
  // far-end receiver detect
  input wire logic detectRequest,
  input wire logic farEndSense,
  output logic rxFound,
  // interrupt
  output logic irq
);
  import rx_pma_status_pkg::*;

  localparam int PASS_WORDS = (PRBS_PERIOD + WORD_W - 1) / WORD_W;
  localparam logic [MATCH_W-1:0] PASS_LAST = MATCH_W'(PASS_WORDS - 1);

  // predicts the next word from the last seven received bits, msb first
  function automatic logic [WORD_W-1:0] prbsPredict(
    input logic [PRBS_ORDER-1:0] s
  );
    logic [PRBS_ORDER-1:0] t;
    logic b;
    t = s;
    prbsPredict = '0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      b = t[6] ^ t[5];
      prbsPredict[i] = b;
      t = {t[5:0], b};
    end
  endfunction

  // true for every mapped register offset
  function automatic logic isMapped(input logic [ADDR_W-1:0] a);
    isMapped = (a == CTRL_OFF) || (a == STATUS_OFF) || (a == ERRCNT_OFF) ||
      (a == IRQ_STAT_OFF) || (a == IRQ_CLR_OFF) || (a == IRQ_EN_OFF);
  endfunction

  logic rstMeta_r, rstSyncB;
  ctrl_s ctrl_r;
  logic [EVT_W-1:0] irqStat_r, irqEn_r;
  logic [DATA_W-1:0] prdata_r;
  logic pslverr_r, dataLock_r, refLock_r, clkSlip_r;
  logic [PRBS_ORDER-1:0] prbsState_r;
  logic captured_r, done_r, detReqPrev_r, rxFound_r;
  logic [MATCH_W-1:0] matchCnt_r;
  logic [1:0] errHold_r;
  logic [ERRCNT_W-1:0] errTotal_r;
  detect_state_e detState_r;
  logic [DET_CNT_W-1:0] detTimer_r;
  logic wrEn, rdSetup, clearAll, wordMatch, errEvent;
  logic detStart, forceData, forceRef;
  evt_s evt;
  logic [STATUS_W-1:0] statusVec;

  // reset release through two flops
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      rstMeta_r <= 1'b0;
      rstSyncB <= 1'b0;
    end else begin
      rstMeta_r <= 1'b1;
      rstSyncB <= rstMeta_r;
    end
  end

  // apb strobes
  assign wrEn = psel && penable && pwrite;
  assign rdSetup = psel && !penable && !pwrite;
  assign pready = psel && penable;
  assign prdata = prdata_r;
  assign pslverr = pslverr_r;

  // control register, start and clear bits self-clear
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      ctrl_r <= CTRL_RST;
    end else if (wrEn && paddr == CTRL_OFF) begin
      ctrl_r <= pwdata[CTRL_W-1:0];
    end else begin
      ctrl_r.detectStart <= 1'b0;
      ctrl_r.prbsClear <= 1'b0;
    end
  end

  // interrupt enable
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      irqEn_r <= IRQ_EN_RST;
    end else if (wrEn && paddr == IRQ_EN_OFF) begin
      irqEn_r <= pwdata[EVT_W-1:0];
    end
  end

  // sticky events, a new event wins over a clear in the same cycle
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      irqStat_r <= '0;
    end else if (wrEn && paddr == IRQ_CLR_OFF) begin
      irqStat_r <= (irqStat_r & ~pwdata[EVT_W-1:0]) | evt;
    end else begin
      irqStat_r <= irqStat_r | evt;
    end
  end

  assign irq = |(irqStat_r & irqEn_r);

  assign statusVec = {detState_r != DET_IDLE, inputLevelDetect, rxFound_r,
    prbsErr, done_r, refLock_r, dataLock_r};

  // read data and error captured in the setup cycle
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      prdata_r <= '0;
      pslverr_r <= 1'b0;
    end else if (psel && !penable) begin
      pslverr_r <= !isMapped(paddr);
      prdata_r <= '0;
      if (rdSetup) begin
        case (paddr)
          CTRL_OFF: prdata_r <= {{(DATA_W-CTRL_W){1'b0}}, ctrl_r};
          STATUS_OFF: prdata_r <= {{(DATA_W-STATUS_W){1'b0}}, statusVec};
          ERRCNT_OFF: prdata_r <= {{(DATA_W-ERRCNT_W){1'b0}}, errTotal_r};
          IRQ_STAT_OFF: prdata_r <= {{(DATA_W-EVT_W){1'b0}}, irqStat_r};
          IRQ_EN_OFF: prdata_r <= {{(DATA_W-EVT_W){1'b0}}, irqEn_r};
          default: prdata_r <= '0;
        endcase
      end
    end
  end

  // lock flags with manual overrides
  assign forceData = forceDataLock || ctrl_r.forceData;
  assign forceRef = forceRefLock || ctrl_r.forceRef;

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      dataLock_r <= 1'b0;
      refLock_r <= 1'b0;
    end else begin
      dataLock_r <= forceData || (!forceRef && cdrDataLock);
      refLock_r <= forceRef || (!forceData && cdrRefLock);
    end
  end

  assign dataLockFlag = dataLock_r;
  assign referenceLockFlag = refLock_r;

  // word alignment slip indication
  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      clkSlip_r <= 1'b0;
    end else begin
      clkSlip_r <= slipDropBit || slipPauseClk;
    end
  end

  assign clkSlip = clkSlip_r;

  // pattern verifier
  assign clearAll = prbsClear || ctrl_r.prbsClear;
  assign wordMatch = prbsPredict(prbsState_r) == rxWord;
  assign errEvent = wordValid && captured_r && done_r && !wordMatch &&
    !clearAll;

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      prbsState_r <= '0;
      captured_r <= 1'b0;
      matchCnt_r <= '0;
      done_r <= 1'b0;
    end else if (clearAll) begin
      prbsState_r <= '0;
      captured_r <= 1'b0;
      matchCnt_r <= '0;
      done_r <= 1'b0;
    end else if (wordValid) begin
      prbsState_r <= rxWord[PRBS_ORDER-1:0];
      captured_r <= 1'b1;
      if (captured_r && !done_r) begin
        if (!wordMatch) begin
          matchCnt_r <= '0;
        end else if (matchCnt_r == PASS_LAST) begin
          done_r <= 1'b1;
        end else begin
          matchCnt_r <= matchCnt_r + 1'b1;
        end
      end
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      errHold_r <= '0;
    end else if (clearAll) begin
      errHold_r <= '0;
    end else if (errEvent) begin
      errHold_r <= ERR_HOLD;
    end else if (errHold_r != 2'h0) begin
      errHold_r <= errHold_r - 1'b1;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      errTotal_r <= '0;
    end else if (clearAll) begin
      errTotal_r <= '0;
    end else if (errEvent && errTotal_r != '1) begin
      errTotal_r <= errTotal_r + 1'b1;
    end
  end

  assign prbsDone = done_r;
  assign prbsErr = errHold_r != 2'h0;

  // level detect passes through unregistered, gated by ctrl_r.levelEn
  assign inputLevelDetect = levelAbove && ctrl_r.levelEn;

  // far-end receiver detect sequencer
  assign detStart = (detectRequest && !detReqPrev_r) || ctrl_r.detectStart;

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      detReqPrev_r <= 1'b0;
    end else begin
      detReqPrev_r <= detectRequest;
    end
  end

  always_ff @(posedge core_clk or negedge rstSyncB) begin
    if (!rstSyncB) begin
      detState_r <= DET_IDLE;
      detTimer_r <= '0;
      rxFound_r <= 1'b0;
    end else begin
      case (detState_r)
        DET_IDLE: begin
          if (detStart) begin
            detState_r <= DET_CHARGE;
            detTimer_r <= DETECT_LOAD;
            rxFound_r <= 1'b0;
          end
        end
        DET_CHARGE: begin
          if (detTimer_r == '0) begin
            detState_r <= DET_SAMPLE;
          end else begin
            detTimer_r <= detTimer_r - 1'b1;
          end
        end
        DET_SAMPLE: begin
          rxFound_r <= farEndSense;
          detState_r <= DET_IDLE;
        end
        default: detState_r <= DET_IDLE;
      endcase
    end
  end

  assign rxFound = rxFound_r;

  // interrupt events
  assign evt.lockLost = dataLock_r && !(forceData || (!forceRef &&
    cdrDataLock));
  assign evt.slip = slipDropBit || slipPauseClk;
  assign evt.prbsErr = errEvent;
  assign evt.prbsDone = !done_r && !clearAll && wordValid && captured_r &&
    wordMatch && matchCnt_r == PASS_LAST;
  assign evt.rxFound = detState_r == DET_SAMPLE && farEndSense;

  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstSyncB);
  a_detect_start: assert property (
    detState_r == DET_IDLE && detStart |=> detState_r == DET_CHARGE
      ##1 (detState_r == DET_CHARGE)[*8])
    else $error("detect request did not start a sequence");
  a_found_set: assert property (
    detState_r == DET_SAMPLE && farEndSense |=> rxFound
      ##1 (rxFound || detState_r != DET_IDLE))
    else $error("receiver found not reported");
  a_slip_pulse: assert property (
    (slipDropBit || slipPauseClk) |=> clkSlip && irqStat_r[3])
    else $error("clock slip not flagged");
  a_data_lock: assert property (
    !forceData && !forceRef |=> dataLockFlag == $past(cdrDataLock))
    else $error("data lock flag does not follow recovery loop");
  a_ref_lock: assert property (
    !forceData && !forceRef |=> referenceLockFlag == $past(cdrRefLock))
    else $error("reference lock flag does not follow recovery loop");
  a_done_pass: assert property (
    $rose(prbsDone) |-> $past(wordValid) && $past(wordMatch) &&
      $past(captured_r) && $past(matchCnt_r) == PASS_LAST)
    else $error("done without a full polynomial pass");
  a_err_after_done: assert property (
    prbsErr |-> prbsDone)
    else $error("mismatch reported before done");
  a_err_three: assert property (
    errEvent |=> prbsErr[*3])
    else $error("error not held for three cycles");
  a_err_ends: assert property (
    errEvent ##1 (!errEvent)[*3] |=> !prbsErr)
    else $error("error held longer than three cycles");
  a_one_per_word: assert property (
    errEvent && errTotal_r != '1 |=> errTotal_r == $past(errTotal_r) + 1'b1)
    else $error("more than one mismatch counted for a word");
  a_clear_done: assert property (
    clearAll |=> !prbsDone && !captured_r && matchCnt_r == '0 && !prbsErr)
    else $error("clear did not restart the verifier");
  a_level_gate: assert property (
    !ctrl_r.levelEn |-> !inputLevelDetect)
    else $error("level detect active while disabled");
endmodule

// >>> tb/prbs_word_source.sv
// prbs_word_source: fabric model sending PRBS7 words to the verifier
// assumes run and corrupt are driven by the bench on core_clk edges
`timescale 1ns/10ps

module prbs_word_source #(
  parameter int WORD_W = 10
) (
  // clock
  input wire logic core_clk,
  // bench control
  input wire logic run,
  input wire logic corrupt,
  // word stream
  output logic wordValid,
  output logic [WORD_W-1:0] rxWord
);
  import rx_pma_status_pkg::*;
  logic [PRBS_ORDER-1:0] seq_r;
  logic [PRBS_ORDER-1:0] seq_nxt;
  logic [WORD_W-1:0] wordNxt;

  initial begin
    seq_r = '1;
    wordValid = 1'h0;
    rxWord = '0;
  end

  // serial x^7+x^6+1, first bit in the msb
  always_comb begin
    seq_nxt = seq_r;
    wordNxt = '0;
    for (int i = WORD_W - 1; i >= 0; i--) begin
      wordNxt[i] = seq_nxt[PRBS_ORDER-1] ^ seq_nxt[PRBS_ORDER-2];
      seq_nxt = {seq_nxt[PRBS_ORDER-2:0], wordNxt[i]};
    end
  end

  // corrupting bits above the state keeps the next prediction intact
  always @(posedge core_clk) begin
    if (run) begin
      wordValid <= 1'h1;
      rxWord <= corrupt ? wordNxt ^ {3'h7, {(WORD_W-3){1'h0}}} : wordNxt;
      seq_r <= seq_nxt;
    end else begin
      wordValid <= 1'h0;
      rxWord <= ~rxWord;
    end
  end
endmodule

// >>> tb/rx_pma_status_tb.sv
// rx_pma_status_tb: registers, lock, slip, verifier, level and detect
// assumes the APB timing and event layout of rx_pma_status
`timescale 1ns/10ps

module rx_pma_status_tb;
  import rx_pma_status_pkg::*;
  logic core_clk = 1'h0;
  logic rstB = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [ADDR_W-1:0] paddr = '0;
  logic [DATA_W-1:0] pwdata = '0;
  logic [DATA_W-1:0] prdata;
  logic pready, pslverr, dataLockFlag, referenceLockFlag, clkSlip;
  logic cdrDataLock = 1'h0;
  logic cdrRefLock = 1'h0;
  logic forceDataLock = 1'h0;
  logic forceRefLock = 1'h0;
  logic slipDropBit = 1'h0;
  logic slipPauseClk = 1'h0;
  logic prbsClear = 1'h0;
  logic levelAbove = 1'h0;
  logic detectRequest = 1'h0;
  logic farEndSense = 1'h0;
  logic run = 1'h0;
  logic corrupt = 1'h0;
  logic wordValid, prbsDone, prbsErr, inputLevelDetect, rxFound, irq;
  logic [9:0] rxWord;
  logic [DATA_W-1:0] rdv;
  logic slv;
  int numErrors = 0;
  int nCompared = 0;
  int n;

  always #50 core_clk = ~core_clk;

  // fabric side double-flop of the asynchronous level detect
  logic [1:0] lvlSync = 2'h0;
  always @(posedge core_clk) lvlSync <= {lvlSync[0], inputLevelDetect};

  rx_pma_status #(.WORD_W(10)) uut (.core_clk(core_clk), .rst_b(rstB),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .cdrDataLock(cdrDataLock), .cdrRefLock(cdrRefLock),
    .forceDataLock(forceDataLock), .forceRefLock(forceRefLock),
    .dataLockFlag(dataLockFlag), .referenceLockFlag(referenceLockFlag),
    .slipDropBit(slipDropBit), .slipPauseClk(slipPauseClk),
    .clkSlip(clkSlip), .wordValid(wordValid), .rxWord(rxWord),
    .prbsClear(prbsClear), .prbsDone(prbsDone), .prbsErr(prbsErr),
    .levelAbove(levelAbove), .inputLevelDetect(inputLevelDetect),
    .detectRequest(detectRequest), .farEndSense(farEndSense),
    .rxFound(rxFound), .irq(irq));

  prbs_word_source #(.WORD_W(10)) src (.core_clk(core_clk), .run(run),
    .corrupt(corrupt), .wordValid(wordValid), .rxWord(rxWord));

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp,
    input string what);
    nCompared++;
    if (seen !== exp) begin
      numErrors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic apb(input logic wr, input logic [ADDR_W-1:0] a,
    input logic [DATA_W-1:0] d);
    @(posedge core_clk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'h1;
    do begin
      @(posedge core_clk);
    end while (pready !== 1'h1);
    rdv = prdata;
    slv = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task automatic rd(input logic [ADDR_W-1:0] a, input logic [31:0] exp,
    input string what);
    apb(1'h0, a, '0);
    chk(rdv, exp, what);
  endtask

  task automatic settle(input int c);
    repeat (c) @(posedge core_clk);
    @(negedge core_clk);
  endtask

  task automatic waitDone(output int m);
    m = 0;
    do begin
      @(negedge core_clk);
      m++;
      chk(prbsErr, 1'h0, "early err");
    end while (prbsDone !== 1'h1 && m < 40);
  endtask

  task automatic wrapUp();
    if (numErrors == 0 && nCompared > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    repeat (2) @(posedge core_clk);
    rstB <= 1'h1;
    repeat (3) @(posedge core_clk);
    rd(CTRL_OFF, 32'(CTRL_RST), "ctrl");
    rd(IRQ_EN_OFF, 32'(IRQ_EN_RST), "irq_en");
    rd(8'h18, 32'h0, "unmapped");
    chk(slv, 1'h1, "slverr");
    // slip from either source, then its event
    for (int i = 0; i < 2; i++) begin
      @(posedge core_clk);
      {slipPauseClk, slipDropBit} <= 2'h1 << i;
      @(posedge core_clk);
      {slipPauseClk, slipDropBit} <= 2'h0;
      @(negedge core_clk);
      chk(clkSlip, 1'h1, "slip");
      settle(1);
      chk(clkSlip, 1'h0, "slip end");
    end
    rd(IRQ_STAT_OFF, 32'h08, "irq_stat");
    apb(1'h1, IRQ_EN_OFF, 32'h08);
    settle(0);
    chk(irq, 1'h1, "irq");
    apb(1'h1, IRQ_EN_OFF, 32'h00);
    settle(0);
    chk(irq, 1'h0, "irq masked");
    apb(1'h1, IRQ_EN_OFF, 32'h08);
    apb(1'h1, IRQ_CLR_OFF, 32'h08);
    settle(0);
    chk(irq, 1'h0, "irq cleared");
    // lock flags and overrides
    @(posedge core_clk);
    cdrDataLock <= 1'h1;
    cdrRefLock <= 1'h1;
    settle(1);
    chk(dataLockFlag, 1'h1, "data lock");
    chk(referenceLockFlag, 1'h1, "ref lock");
    @(posedge core_clk);
    forceDataLock <= 1'h1;
    settle(1);
    chk({dataLockFlag, referenceLockFlag}, 2'h2, "force data");
    @(posedge core_clk);
    forceDataLock <= 1'h0;
    forceRefLock <= 1'h1;
    settle(1);
    chk({dataLockFlag, referenceLockFlag}, 2'h1, "force ref");
    @(posedge core_clk);
    forceRefLock <= 1'h0;
    cdrDataLock <= 1'h0;
    cdrRefLock <= 1'h0;
    settle(1);
    chk(dataLockFlag, 1'h0, "data unlock");
    chk(referenceLockFlag, 1'h0, "ref unlock");
    apb(1'h1, CTRL_OFF, 32'h05);
    settle(1);
    chk({dataLockFlag, referenceLockFlag}, 2'h2, "reg force data");
    apb(1'h1, CTRL_OFF, 32'h06);
    settle(1);
    chk({dataLockFlag, referenceLockFlag}, 2'h1, "reg force ref");
    apb(1'h1, CTRL_OFF, 32'(CTRL_RST));
    // level detect, gated by its enable
    @(posedge core_clk);
    levelAbove <= 1'h1;
    settle(0);
    chk(inputLevelDetect, 1'h1, "level");
    settle(2);
    chk(lvlSync[1], 1'h1, "level synced");
    apb(1'h1, CTRL_OFF, 32'h0);
    settle(0);
    chk(inputLevelDetect, 1'h0, "level off");
    apb(1'h1, CTRL_OFF, 32'(CTRL_RST));
    // verifier: pass, single and back-to-back errors, clear
    @(posedge core_clk);
    run <= 1'h1;
    waitDone(n);
    chk(32'(n >= 16 && n <= 17), 32'h1, "done delay");
    // one stretched parallel period: the stream pauses a single word
    @(posedge core_clk);
    run <= 1'h0;
    @(posedge core_clk);
    run <= 1'h1;
    settle(3);
    chk(prbsErr, 1'h0, "stretched word");
    for (int k = 1; k <= 2; k++) begin
      @(posedge core_clk);
      corrupt <= 1'h1;
      repeat (k) @(posedge core_clk);
      corrupt <= 1'h0;
      n = 0;
      repeat (12) begin
        @(negedge core_clk);
        n += int'(prbsErr === 1'h1);
      end
      chk(32'(n), 32'(k + 2), "err cycles");
      rd(ERRCNT_OFF, 32'(k * (k + 1) / 2), "errcnt");
    end
    @(posedge core_clk);
    prbsClear <= 1'h1;
    @(posedge core_clk);
    prbsClear <= 1'h0;
    corrupt <= 1'h1;
    @(posedge core_clk);
    corrupt <= 1'h0;
    settle(0);
    chk(prbsDone, 1'h0, "done cleared");
    rd(ERRCNT_OFF, 32'h0, "errcnt cleared");
    waitDone(n);
    chk(prbsDone, 1'h1, "done again");
    @(posedge core_clk);
    run <= 1'h0;
    // far-end receiver detect
    @(posedge core_clk);
    farEndSense <= 1'h1;
    detectRequest <= 1'h1;
    @(posedge core_clk);
    detectRequest <= 1'h0;
    rd(STATUS_OFF, 32'h64, "busy status");
    n = 0;
    do begin
      @(negedge core_clk);
      n++;
    end while (rxFound !== 1'h1 && n < 200);
    chk(32'(n >= 96 && n <= 100), 32'h1, "found delay");
    @(posedge core_clk);
    farEndSense <= 1'h0;
    apb(1'h1, CTRL_OFF, 32'h14);
    settle(2);
    chk(rxFound, 1'h0, "found restart");
    settle(110);
    chk(rxFound, 1'h0, "nobody found");
    apb(1'h1, CTRL_OFF, 32'h0C);
    settle(1);
    chk(prbsDone, 1'h0, "reg clear");
    wrapUp();
  end

  initial begin
    repeat (3000) @(posedge core_clk);
    numErrors++;
    wrapUp();
  end
endmodule
